/* common/lpci_map.svh */
// Constants for the LPDDR pin command interface
// Assumes inclusion by the package and the design file
`ifndef LPCI_MAP_SVH
`define LPCI_MAP_SVH
`define LPCI_ADDR_W    14
`define LPCI_BANKS     4
`define LPCI_BA_W      2
`define LPCI_BYTES     2
`define LPCI_AP_BIT    10
`define LPCI_COL_W     2
`define LPCI_MEM_WORDS 16
`define LPCI_TEMP_W    8
`define LPCI_TEMP_LIM  8'h55
`define LPCI_CMD_LMR   3'h0
`define LPCI_CMD_REF   3'h1
`define LPCI_CMD_PRE   3'h2
`define LPCI_CMD_ACT   3'h3
`define LPCI_CMD_WR    3'h4
`define LPCI_CMD_RD    3'h5
`define LPCI_CMD_BST   3'h6
`define LPCI_CMD_NOP   3'h7
`endif

/* common/lpci_pkg.sv */
// Types for the LPDDR pin command interface
// Assumes lpci_map.svh on the include path
`include "lpci_map.svh"
package lpci_pkg;
  typedef enum logic [1:0] {
    LPCI_RUN,
    LPCI_PDN_PRE,
    LPCI_PDN_ACT,
    LPCI_SREF
  } lpci_pwr_t;

  typedef struct packed {
    logic                    select_n;
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic [`LPCI_BA_W-1:0]   ba;
    logic [`LPCI_ADDR_W-1:0] addr;
  } lpci_cmd_t;

  typedef struct packed {
    logic [8*`LPCI_BYTES-1:0] rise;
    logic [8*`LPCI_BYTES-1:0] fall;
  } lpci_beat_t;

  typedef struct packed {
    logic [`LPCI_BYTES-1:0] rise;
    logic [`LPCI_BYTES-1:0] fall;
  } lpci_lane_t;
endpackage : lpci_pkg

/* hdl/lpci_device.sv */
// LPDDR device-side pin command and data interface
// Assumes pins already sampled in the clk domain; DDR beats arrive as rise/fall pairs
//
// Operation
// - Sample address and control on clock edge
// - Two data beats per clock cycle
// - Clock gate high runs clocks, buffers, drivers
// - Gate low enters precharge, self, active power-down
// - Clock gate sampled; self refresh exit also sampled on clock edge
// - Power-down disables all inputs except gate and die temperature
// - Select high masks every command
// - Command code from row, column, write strobes
// - Masked write beats are not stored
// - Mask captured on both strobe edges
// - Bank address selects target bank
// - Bank address picks mode register
// - Row on activate; column and autoprecharge on access
// - Precharge one bank or all by bit ten
// - Mode opcode from fourteen address bits
// - Read strobe edge-aligned; write strobe captures data
// - Temperature alarm high above threshold
`timescale 1ns/100ps
`default_nettype none
`include "lpci_map.svh"
module lpci_device
  import lpci_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                rank0_clock_gate,
  input  wire lpci_cmd_t                           cmd_in,
  input  wire lpci_beat_t                          dq_in,
  input  wire lpci_lane_t                          byte_write_mask,
  input  wire lpci_lane_t                          byte_data_strobe_in,
  input  wire logic [`LPCI_TEMP_W-1:0]             die_temp,
  output lpci_beat_t                               dq_out,
  output logic                                     dq_oe,
  output lpci_lane_t                               byte_data_strobe_out,
  output logic                                     byte_data_strobe_oe,
  output logic                                     core_clk_run,
  output logic                                     input_buf_en,
  output logic                                     out_drv_en,
  output lpci_pwr_t                                pwr_state,
  output logic [`LPCI_BANKS-1:0]                   bank_open,
  output logic [`LPCI_BANKS-1:0][`LPCI_ADDR_W-1:0] open_row,
  output logic [`LPCI_BANKS-1:0][`LPCI_ADDR_W-1:0] mode_regs,
  output logic                                     temp_alarm_out
);

  // ****************************************
  // Command decode
  // ****************************************
  function automatic logic [2:0] cmd_code(input lpci_cmd_t c);
    cmd_code = {c.ras_n, c.cas_n, c.we_n};
  endfunction : cmd_code

  function automatic logic [$clog2(`LPCI_MEM_WORDS)-1:0] mem_index(input lpci_cmd_t c);
    mem_index = {c.ba, c.addr[`LPCI_COL_W-1:0]};
  endfunction : mem_index

  lpci_pwr_t pwr_r;
  logic      cmd_ok;
  logic [2:0] code;
  logic      is_act;
  logic      is_rd;
  logic      is_wr;
  logic      is_pre;
  logic      is_lmr;
  logic      is_ref;

  assign code   = cmd_code(cmd_in);
  assign cmd_ok = (pwr_r == LPCI_RUN) && rank0_clock_gate && !cmd_in.select_n;
  assign is_act = cmd_ok && (code == `LPCI_CMD_ACT);
  assign is_rd  = cmd_ok && (code == `LPCI_CMD_RD);
  assign is_wr  = cmd_ok && (code == `LPCI_CMD_WR);
  assign is_pre = cmd_ok && (code == `LPCI_CMD_PRE);
  assign is_lmr = cmd_ok && (code == `LPCI_CMD_LMR);
  assign is_ref = (pwr_r == LPCI_RUN) && !cmd_in.select_n && (code == `LPCI_CMD_REF);

  // ****************************************
  // Power state
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_r <= LPCI_RUN;
    end else begin
      case (pwr_r)
        LPCI_RUN: begin
          if (!rank0_clock_gate) begin
            if (bank_open != '0) begin
              pwr_r <= LPCI_PDN_ACT;
            end else if (is_ref) begin
              pwr_r <= LPCI_SREF;
            end else begin
              pwr_r <= LPCI_PDN_PRE;
            end
          end
        end
        LPCI_PDN_PRE, LPCI_PDN_ACT: begin
          if (rank0_clock_gate) begin
            pwr_r <= LPCI_RUN;
          end
        end
        LPCI_SREF: begin
          if (rank0_clock_gate) begin
            pwr_r <= LPCI_RUN;
          end
        end
        default: pwr_r <= LPCI_RUN;
      endcase
    end
  end

  assign pwr_state    = pwr_r;
  assign core_clk_run = (pwr_r == LPCI_RUN) && rank0_clock_gate;
  assign input_buf_en = (pwr_r == LPCI_RUN);
  assign out_drv_en   = core_clk_run;

  // ****************************************
  // Bank state
  // ****************************************
  logic [`LPCI_BANKS-1:0]                   open_r;
  logic [`LPCI_BANKS-1:0][`LPCI_ADDR_W-1:0] row_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      open_r <= '0;
    end else if (is_act) begin
      open_r[cmd_in.ba] <= 1'b1;
    end else if (is_pre) begin
      if (cmd_in.addr[`LPCI_AP_BIT]) begin
        open_r <= '0;
      end else begin
        open_r[cmd_in.ba] <= 1'b0;
      end
    end else if ((is_rd || is_wr) && cmd_in.addr[`LPCI_AP_BIT]) begin
      open_r[cmd_in.ba] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      row_r <= '0;
    end else if (is_act) begin
      row_r[cmd_in.ba] <= cmd_in.addr;
    end
  end

  assign bank_open = open_r;
  assign open_row  = row_r;

  // ****************************************
  // Mode registers
  // ****************************************
  logic [`LPCI_BANKS-1:0][`LPCI_ADDR_W-1:0] mode_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= '0;
    end else if (is_lmr) begin
      mode_r[cmd_in.ba] <= cmd_in.addr;
    end
  end

  assign mode_regs = mode_r;

  // ****************************************
  // Write path
  // ****************************************
  logic [2*8*`LPCI_BYTES-1:0] mem_r [`LPCI_MEM_WORDS];
  logic                                   wr_pend_r;
  logic [$clog2(`LPCI_MEM_WORDS)-1:0]     wr_idx_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= '0;
    end else begin
      wr_pend_r <= is_wr;
      if (is_wr) begin
        wr_idx_r <= mem_index(cmd_in);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_pend_r) begin
      for (int b = 0; b < `LPCI_BYTES; b++) begin
        if (byte_data_strobe_in.rise[b] && !byte_write_mask.rise[b]) begin
          mem_r[wr_idx_r][8*`LPCI_BYTES+8*b +: 8] <= dq_in.rise[8*b +: 8];
        end
        if (byte_data_strobe_in.fall[b] && !byte_write_mask.fall[b]) begin
          mem_r[wr_idx_r][8*b +: 8] <= dq_in.fall[8*b +: 8];
        end
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  lpci_beat_t dq_out_r;
  logic       rd_oe_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      dq_out_r <= '0;
      rd_oe_r  <= 1'b0;
    end else begin
      rd_oe_r <= is_rd;
      if (is_rd) begin
        dq_out_r.rise <= mem_r[mem_index(cmd_in)][2*8*`LPCI_BYTES-1:8*`LPCI_BYTES];
        dq_out_r.fall <= mem_r[mem_index(cmd_in)][8*`LPCI_BYTES-1:0];
      end
    end
  end

  assign dq_out                    = dq_out_r;
  assign dq_oe                     = rd_oe_r && out_drv_en;
  assign byte_data_strobe_out      = {{`LPCI_BYTES{rd_oe_r}}, {`LPCI_BYTES{1'b0}}};
  assign byte_data_strobe_oe       = dq_oe;

  // ****************************************
  // Temperature alarm
  // ****************************************
  logic temp_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      temp_r <= 1'b0;
    end else begin
      temp_r <= (die_temp > `LPCI_TEMP_LIM);
    end
  end

  assign temp_alarm_out = temp_r;

  // ****************************************
  // Checks
  // ****************************************
  cs_mask_a: assert property (@(posedge clk) disable iff (rst)
    cmd_in.select_n |=> $stable(open_r) && $stable(mode_r))
    else $error("Command taken while deselected");

  act_open_a: assert property (@(posedge clk) disable iff (rst)
    is_act |=> open_r[$past(cmd_in.ba)] && row_r[$past(cmd_in.ba)] == $past(cmd_in.addr))
    else $error("Activate did not open bank");

  pre_all_a: assert property (@(posedge clk) disable iff (rst)
    is_pre && cmd_in.addr[`LPCI_AP_BIT] |=> open_r == '0)
    else $error("Precharge all left a bank open");

  pre_one_a: assert property (@(posedge clk) disable iff (rst)
    is_pre && !cmd_in.addr[`LPCI_AP_BIT] |=>
      !open_r[$past(cmd_in.ba)] && ((open_r ^ $past(open_r)) & ~(4'h1 << $past(cmd_in.ba))) == '0)
    else $error("Single precharge touched other banks");

  lmr_load_a: assert property (@(posedge clk) disable iff (rst)
    is_lmr |=> mode_r[$past(cmd_in.ba)] == $past(cmd_in.addr))
    else $error("Mode register not loaded");

  pdn_enter_a: assert property (@(posedge clk) disable iff (rst)
    pwr_r == LPCI_RUN && !rank0_clock_gate && open_r != '0 |=> pwr_r == LPCI_PDN_ACT ##1
      (pwr_r == LPCI_PDN_ACT || pwr_r == LPCI_RUN))
    else $error("Active power-down not entered");

  sref_enter_a: assert property (@(posedge clk) disable iff (rst)
    pwr_r == LPCI_RUN && !rank0_clock_gate && open_r == '0 && is_ref |=> pwr_r == LPCI_SREF)
    else $error("Self refresh not entered");

  buf_off_a: assert property (@(posedge clk) disable iff (rst)
    pwr_r != LPCI_RUN |-> !input_buf_en && !core_clk_run && !dq_oe)
    else $error("Buffers live in power-down");

  rd_edge_a: assert property (@(posedge clk) disable iff (rst)
    is_rd ##1 rank0_clock_gate |-> byte_data_strobe_oe && byte_data_strobe_out.rise == 2'h3
      && byte_data_strobe_out.fall == 2'h0)
    else $error("Read strobe not edge aligned");

  wr_mask_rise_a: assert property (@(posedge clk) disable iff (rst)
    wr_pend_r && byte_write_mask.rise[0] |=>
      mem_r[$past(wr_idx_r)][8*`LPCI_BYTES +: 8] == $past(mem_r[wr_idx_r][8*`LPCI_BYTES +: 8]))
    else $error("Masked rise byte was written");

  wr_mask_fall_a: assert property (@(posedge clk) disable iff (rst)
    wr_pend_r && byte_write_mask.fall[0] |=>
      mem_r[$past(wr_idx_r)][0 +: 8] == $past(mem_r[wr_idx_r][0 +: 8]))
    else $error("Masked fall byte was written");

  auto_pre_a: assert property (@(posedge clk) disable iff (rst)
    (is_rd || is_wr) && cmd_in.addr[`LPCI_AP_BIT] |=> !open_r[$past(cmd_in.ba)])
    else $error("Auto precharge left bank open");

  temp_alarm_a: assert property (@(posedge clk) disable iff (rst)
    die_temp > `LPCI_TEMP_LIM ##1 die_temp > `LPCI_TEMP_LIM |-> temp_alarm_out)
    else $error("Temperature alarm missing");

  temp_clear_a: assert property (@(posedge clk) disable iff (rst)
    !(die_temp > `LPCI_TEMP_LIM) |=> !temp_alarm_out)
    else $error("Temperature alarm stuck high");

endmodule : lpci_device
`default_nettype wire

/* verification/lpci_ctrl_model.sv */
// Controller-side model: drives commands, clock gate and write beats
// Assumes the bench calls its tasks from one process in step with clk
`timescale 1ns/100ps
`default_nettype none
`include "lpci_map.svh"
module lpci_ctrl_model
  import lpci_pkg::*;
(
  input  wire logic clk,
  output var  logic       gate,
  output var  lpci_cmd_t  cmd,
  output var  lpci_beat_t dq,
  output var  lpci_lane_t mask,
  output var  lpci_lane_t dqs
);
  // ************************
  // Command and data drive
  // ************************
  initial begin
    gate = 1'b1;
    cmd  = {1'b1, `LPCI_CMD_NOP, 16'h0000};
    dq   = '0;
    mask = '0;
    dqs  = '0;
  end

  task issue(input logic [2:0] code, input logic [1:0] ba, input logic [13:0] a, input logic sn, input logic g);
    @(negedge clk);
    gate <= g;
    cmd  <= {sn, code, ba, a};
    @(negedge clk);
    cmd  <= {1'b1, `LPCI_CMD_NOP, ba, a};
  endtask : issue

  task wr(input logic [1:0] ba, input logic [13:0] col, input logic [31:0] d, input logic [3:0] m, input logic [3:0] s);
    issue(`LPCI_CMD_WR, ba, col, 1'b0, 1'b1);
    dq   <= d;
    mask <= m;
    dqs  <= s;
    @(negedge clk);
    dq   <= ~d;
    mask <= ~m;
    dqs  <= '0;
  endtask : wr
endmodule : lpci_ctrl_model
`default_nettype wire

/* verification/lpci_device_test.sv */
// Self-checking bench for the device pin command interface
// Assumes the controller model drives every command and write beat
`timescale 1ns/100ps
`default_nettype none
`include "lpci_map.svh"
module lpci_device_test
  import lpci_pkg::*;
;
  logic clk, rst, gate, dq_oe, dqs_oe, clk_run, in_en, drv_en, alarm;
  logic [7:0] die_temp;
  lpci_cmd_t cmd;
  lpci_beat_t dq, dq_out;
  lpci_lane_t mask, dqs, dqs_out;
  lpci_pwr_t pwr;
  logic [3:0] open_b;
  logic [3:0][13:0] rows, mregs;
  int n_mismatch = 0;
  int compares = 0;

  lpci_ctrl_model ctl (.clk(clk), .gate(gate), .cmd(cmd), .dq(dq), .mask(mask), .dqs(dqs));
  lpci_device uut (.clk(clk), .rst(rst), .rank0_clock_gate(gate), .cmd_in(cmd), .dq_in(dq),
    .byte_write_mask(mask), .byte_data_strobe_in(dqs), .die_temp(die_temp), .dq_out(dq_out),
    .dq_oe(dq_oe), .byte_data_strobe_out(dqs_out), .byte_data_strobe_oe(dqs_oe),
    .core_clk_run(clk_run), .input_buf_en(in_en), .out_drv_en(drv_en), .pwr_state(pwr),
    .bank_open(open_b), .open_row(rows), .mode_regs(mregs), .temp_alarm_out(alarm));

  // ************************
  // Checks and scenarios
  // ************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task t_banks;
    ctl.issue(`LPCI_CMD_ACT, 2'h1, 14'h1abc, 1'b0, 1'b1);
    chk(32'(rows[1]), 32'h1abc);
    ctl.issue(`LPCI_CMD_ACT, 2'h2, 14'h0123, 1'b1, 1'b1);
    chk(32'(open_b), 32'h2);
    ctl.issue(`LPCI_CMD_ACT, 2'h2, 14'h0123, 1'b0, 1'b1);
    ctl.issue(`LPCI_CMD_BST, 2'h2, 14'h0400, 1'b0, 1'b1);
    chk(32'(open_b), 32'h6);
    ctl.issue(`LPCI_CMD_PRE, 2'h1, 14'h0000, 1'b0, 1'b1);
    chk(32'(open_b), 32'h4);
    ctl.issue(`LPCI_CMD_ACT, 2'h1, 14'h0001, 1'b0, 1'b1);
    ctl.issue(`LPCI_CMD_PRE, 2'h0, 14'h0400, 1'b0, 1'b1);
    chk(32'(open_b), 32'h0);
  endtask : t_banks

  task t_modes;
    for (int i = 0; i < 4; i++) begin
      ctl.issue(`LPCI_CMD_LMR, 2'(i), 14'h2aa5 ^ 14'(i), 1'b0, 1'b1);
      chk(32'(mregs[i]), 32'(14'h2aa5 ^ 14'(i)));
    end
    chk(32'(mregs[0]), 32'h2aa5);
  endtask : t_modes

  task t_data;
    ctl.issue(`LPCI_CMD_ACT, 2'h0, 14'h0007, 1'b0, 1'b1);
    ctl.wr(2'h0, 14'h0001, 32'haabbccdd, 4'h0, 4'hf);
    ctl.wr(2'h0, 14'h0001, 32'h11223344, 4'h5, 4'hd);
    ctl.issue(`LPCI_CMD_RD, 2'h0, 14'h0001, 1'b0, 1'b1);
    chk(dq_out, 32'h11bbccdd);
    chk({26'h0, dq_oe, dqs_oe, dqs_out}, 32'h3c);
    ctl.issue(`LPCI_CMD_RD, 2'h0, 14'h0401, 1'b0, 1'b1);
    chk({27'h0, dq_oe, open_b}, 32'h10);
    @(negedge clk);
    chk({31'h0, dq_oe}, 32'h0);
    ctl.issue(`LPCI_CMD_ACT, 2'h0, 14'h0007, 1'b0, 1'b1);
    chk(32'(open_b), 32'h1);
    ctl.wr(2'h0, 14'h0402, 32'h55667788, 4'h0, 4'hf);
    chk(32'(open_b), 32'h0);
    ctl.issue(`LPCI_CMD_RD, 2'h0, 14'h0002, 1'b0, 1'b1);
    chk(dq_out, 32'h55667788);
  endtask : t_data

  task t_power;
    ctl.issue(`LPCI_CMD_ACT, 2'h3, 14'h0055, 1'b0, 1'b1);
    ctl.issue(`LPCI_CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b0);
    chk(32'(pwr), 32'(LPCI_PDN_ACT));
    chk({29'h0, clk_run, in_en, drv_en}, 32'h0);
    ctl.issue(`LPCI_CMD_PRE, 2'h0, 14'h0400, 1'b0, 1'b0);
    chk(32'(open_b), 32'h8);
    ctl.issue(`LPCI_CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b1);
    chk(32'(pwr), 32'(LPCI_RUN));
    ctl.issue(`LPCI_CMD_PRE, 2'h0, 14'h0400, 1'b0, 1'b1);
    ctl.issue(`LPCI_CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b0);
    chk(32'(pwr), 32'(LPCI_PDN_PRE));
    ctl.issue(`LPCI_CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b1);
    ctl.issue(`LPCI_CMD_REF, 2'h0, 14'h0000, 1'b0, 1'b0);
    chk(32'(pwr), 32'(LPCI_SREF));
    ctl.issue(`LPCI_CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b1);
    chk({29'h0, clk_run, in_en, drv_en}, 32'h7);
  endtask : t_power

  task t_temp;
    die_temp <= 8'h55;
    @(negedge clk);
    chk({31'h0, alarm}, 32'h0);
    die_temp <= 8'h56;
    @(negedge clk);
    chk({31'h0, alarm}, 32'h1);
    @(negedge clk);
    chk({31'h0, alarm}, 32'h1);
    die_temp <= 8'h00;
    @(negedge clk);
    chk({31'h0, alarm}, 32'h0);
  endtask : t_temp

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #50000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    die_temp = 8'h00;
    repeat (16) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({28'h0, clk_run, in_en, drv_en, dq_oe}, 32'he);
    t_banks();
    t_modes();
    t_data();
    t_power();
    t_temp();
    finish_test();
  end
endmodule : lpci_device_test
`default_nettype wire
